// ==== verilog/pde_ports.sv ====
// Port D / port E pin register block: decode, registers, pin control
`timescale 1ns/1ps
module pde_ports
	import pde_pkg::*;
(
	input  wire logic                        CLOCK,      // 250 MHz clock
	input  wire logic                        RESETN,     // Sync reset, low
	input  wire logic                        IO_SEL,     // 1: I/O-space access
	input  wire logic [pde_pkg::ADDR_W-1:0]  ADDR,       // Address
	input  wire logic                        WR,         // Write strobe
	input  wire logic                        RD,         // Read strobe
	input  wire logic [pde_pkg::DATA_W-1:0]  WDATA,      // Write data
	output logic      [pde_pkg::DATA_W-1:0]  RDATA,      // Read data
	output logic                             RVALID,     // Read data valid
	input  wire logic                        VP_WR,      // Virtual dir write
	input  wire logic                        VP_RD,      // Virtual dir read
	input  wire logic                        VP_PORT,    // 0: port D, 1: E
	input  wire logic [pde_pkg::DATA_W-1:0]  VP_WDATA,   // Virtual write data
	output logic      [pde_pkg::DATA_W-1:0]  VP_RDATA,   // Virtual read data
	output logic                             VP_RVALID,  // Virtual read valid
	input  wire logic [pde_pkg::PD_W-1:0]    PD_IN,      // Port D pin levels
	output logic      [pde_pkg::PD_W-1:0]    PD_OE,      // Port D drive enable
	output logic      [pde_pkg::PD_W-1:0]    PD_TOGGLE,  // Port D toggle pulse
	input  wire logic [pde_pkg::PE_W-1:0]    PE_IN,      // Port E pin levels
	output logic      [pde_pkg::PE_W-1:0]    PE_OUT,     // Port E pin value
	output logic      [pde_pkg::PE_W-1:0]    PE_OE       // Port E drive enable
);
	import pde_pkg::*;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// An I/O-space address has only six bits, so the extended area
	// from 0x60 upward can never be reached that way.
	function automatic pde_sel_t decode(input logic io,
	                                    input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] dat;
		dat = a;
		decode = SEL_NONE;
		if (io) begin
			dat = 16'({10'h000, a[IOA_W-1:0]}) + IO_OFFSET;
		end
		if (!io || dat <= IO_LAST + IO_OFFSET) begin
			case (dat)
				ADR_PD_PIN: decode = SEL_PD_PIN;
				ADR_PD_DIR: decode = SEL_PD_DIR;
				ADR_PE_PIN: decode = SEL_PE_PIN;
				ADR_PE_DIR: decode = SEL_PE_DIR;
				ADR_PE_OUT: decode = SEL_PE_OUT;
				default:    decode = SEL_NONE;
			endcase
		end
	endfunction : decode

	pde_sel_t          wr_sel;
	pde_sel_t          rd_sel;

	// Upper address bits of an I/O access are ignored; a data address is not offset, so a load/store
	// to 0x0a (below the register window) hits nothing.
	always_comb begin
		wr_sel = WR ? decode(IO_SEL, ADDR) : SEL_NONE;
		rd_sel = RD ? decode(IO_SEL, ADDR) : SEL_NONE;
	end

	// ------------------------------------------------------------
	// Direction registers
	// ------------------------------------------------------------
	logic              pd_dir_we;
	logic [PD_W-1:0]   pd_dir_wdata;
	logic [PD_W-1:0]   pd_dir;
	logic              pe_dir_we;
	logic [PE_W-1:0]   pe_dir_wdata;
	logic [PE_W-1:0]   pe_dir;

	// The CPU bus wins a same-cycle collision with the virtual path;
	// both land in the one register, so neither can see a copy.
	always_comb begin
		pd_dir_we    = 1'b0;
		pd_dir_wdata = WDATA;
		pe_dir_we    = 1'b0;
		pe_dir_wdata = WDATA[PE_W-1:0];
		if (wr_sel == SEL_PD_DIR) begin
			pd_dir_we = 1'b1;
		end else if (VP_WR && VP_PORT == VP_PORT_D) begin
			pd_dir_we    = 1'b1;
			pd_dir_wdata = VP_WDATA;
		end
		if (wr_sel == SEL_PE_DIR) begin
			pe_dir_we = 1'b1;
		end else if (VP_WR && VP_PORT == VP_PORT_E) begin
			pe_dir_we    = 1'b1;
			pe_dir_wdata = VP_WDATA[PE_W-1:0];
		end
	end

	pde_dir_reg #(
		.W   (PD_W),
		.RST (PD_DIR_RST)
	) u_pd_dir (
		.clk   (CLOCK),
		.rst_n (RESETN),
		.we    (pd_dir_we),
		.wdata (pd_dir_wdata),
		.q     (pd_dir)
	);

	pde_dir_reg #(
		.W   (PE_W),
		.RST (PE_DIR_RST)
	) u_pe_dir (
		.clk   (CLOCK),
		.rst_n (RESETN),
		.we    (pe_dir_we),
		.wdata (pe_dir_wdata),
		.q     (pe_dir)
	);

	// ------------------------------------------------------------
	// Port E output data with toggle
	// ------------------------------------------------------------
	logic              pe_out_we;
	logic              pe_tgl;
	logic [PE_W-1:0]   pe_out;

	always_comb begin
		pe_out_we = (wr_sel == SEL_PE_OUT);
		pe_tgl    = (wr_sel == SEL_PE_PIN);
	end

	pde_out_reg #(
		.W   (PE_W),
		.RST (PE_OUT_RST)
	) u_pe_out (
		.clk      (CLOCK),
		.rst_n    (RESETN),
		.we       (pe_out_we),
		.wdata    (WDATA[PE_W-1:0]),
		.tgl      (pe_tgl),
		.tgl_mask (WDATA[PE_W-1:0]),
		.q        (pe_out)
	);

	// ------------------------------------------------------------
	// Pin drive and port D toggle request
	// ------------------------------------------------------------
	// The port D data register lives outside this block; a pin input
	// write is passed on as a one-cycle mask of bits to invert.
	logic [PD_W-1:0]   pd_oe_reg;
	logic [PD_W-1:0]   pd_oe_next;
	logic [PD_W-1:0]   pd_tgl_reg;
	logic [PD_W-1:0]   pd_tgl_next;
	logic [PE_W-1:0]   pe_oe_reg;
	logic [PE_W-1:0]   pe_oe_next;
	logic [PE_W-1:0]   pe_pin_reg;
	logic [PE_W-1:0]   pe_pin_next;

	always_comb begin
		pd_oe_next  = pd_dir_next_view();
		pe_oe_next  = pe_dir_next_view();
		pe_pin_next = pe_out_next_view();
		pd_tgl_next = '0;
		if (wr_sel == SEL_PD_PIN) begin
			pd_tgl_next = WDATA;
		end
	end

	// Lookahead views let the pin outputs be flops yet change on the
	// same edge as the registers they copy.
	function automatic logic [PD_W-1:0] pd_dir_next_view();
		pd_dir_next_view = pd_dir_we ? pd_dir_wdata : pd_dir;
	endfunction : pd_dir_next_view

	function automatic logic [PE_W-1:0] pe_dir_next_view();
		pe_dir_next_view = pe_dir_we ? pe_dir_wdata : pe_dir;
	endfunction : pe_dir_next_view

	function automatic logic [PE_W-1:0] pe_out_next_view();
		if (pe_out_we) begin
			pe_out_next_view = WDATA[PE_W-1:0];
		end else if (pe_tgl) begin
			pe_out_next_view = pe_out ^ WDATA[PE_W-1:0];
		end else begin
			pe_out_next_view = pe_out;
		end
	endfunction : pe_out_next_view

	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			pd_oe_reg  <= PD_DIR_RST;
			pd_tgl_reg <= '0;
			pe_oe_reg  <= PE_DIR_RST;
			pe_pin_reg <= PE_OUT_RST;
		end else begin
			pd_oe_reg  <= pd_oe_next;
			pd_tgl_reg <= pd_tgl_next;
			pe_oe_reg  <= pe_oe_next;
			pe_pin_reg <= pe_pin_next;
		end
	end

	assign PD_OE     = pd_oe_reg;
	assign PD_TOGGLE = pd_tgl_reg;
	assign PE_OE     = pe_oe_reg;
	assign PE_OUT    = pe_pin_reg;

	// ------------------------------------------------------------
	// Read paths
	// ------------------------------------------------------------
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic              rvalid_reg;
	logic              rvalid_next;
	logic [DATA_W-1:0] vp_rdata_reg;
	logic [DATA_W-1:0] vp_rdata_next;
	logic              vp_rvalid_reg;
	logic              vp_rvalid_next;

	// Unmapped addresses and unused upper port E bits read zero.
	always_comb begin
		rvalid_next = RD;
		case (rd_sel)
			SEL_PD_PIN: rdata_next = PD_IN;
			SEL_PD_DIR: rdata_next = pd_dir;
			SEL_PE_PIN: rdata_next = {4'h0, PE_IN};
			SEL_PE_DIR: rdata_next = {4'h0, pe_dir};
			SEL_PE_OUT: rdata_next = {4'h0, pe_out};
			default:    rdata_next = RD_ZERO;
		endcase
		vp_rvalid_next = VP_RD;
		vp_rdata_next  = RD_ZERO;
		if (VP_RD) begin
			vp_rdata_next = (VP_PORT == VP_PORT_D) ? pd_dir
			                                       : {4'h0, pe_dir};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RESETN) begin
			rdata_reg     <= RD_ZERO;
			rvalid_reg    <= 1'b0;
			vp_rdata_reg  <= RD_ZERO;
			vp_rvalid_reg <= 1'b0;
		end else begin
			rdata_reg     <= rdata_next;
			rvalid_reg    <= rvalid_next;
			vp_rdata_reg  <= vp_rdata_next;
			vp_rvalid_reg <= vp_rvalid_next;
		end
	end

	assign RDATA     = rdata_reg;
	assign RVALID    = rvalid_reg;
	assign VP_RDATA  = vp_rdata_reg;
	assign VP_RVALID = vp_rvalid_reg;
endmodule : pde_ports

// ==== verilog/pde_pkg.sv ====
// Constants and types for the port D / port E pin register block
// What this block does
// - A short I/O-space access reaches each register at its data address minus 0x20, within I/O range 0x00 to 0x3F.
// - Port D direction sits at data 0x2A (I/O 0x0A), eight read/write bits clearing to 0x00.
// - Port D pin input sits at data 0x29 (I/O 0x09) and reads the eight pin levels.
// - Port E output data sits at data 0x2E (I/O 0x0E), bits 3..0 read/write, clearing to zero.
// - Port E direction sits at data 0x2D (I/O 0x0D), bits 3..0 read/write, clearing to zero.
// - Port E pin input sits at data 0x2C (I/O 0x0C) and reads pin levels on bits 3..0.
// - Each direction bit sets the direction of its own pin independently.
// - Virtual-port access to direction bits reaches the real direction register, but a virtual write loses to a same-cycle CPU write to it.
// - A write to a pin input register stores nothing and toggles the matching outputs instead.
package pde_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int PD_W   = 8;
	localparam int PE_W   = 4;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 16;
	localparam int IOA_W  = 6;

	// ------------------------------------------------------------
	// Address map (data space) and I/O window
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] IO_OFFSET   = 16'h0020;
	localparam logic [ADDR_W-1:0] IO_LAST     = 16'h003f;
	localparam logic [ADDR_W-1:0] EXT_IO_BASE = 16'h0060;
	localparam logic [ADDR_W-1:0] ADR_PD_PIN  = 16'h0029;
	localparam logic [ADDR_W-1:0] ADR_PD_DIR  = 16'h002a;
	localparam logic [ADDR_W-1:0] ADR_PE_PIN  = 16'h002c;
	localparam logic [ADDR_W-1:0] ADR_PE_DIR  = 16'h002d;
	localparam logic [ADDR_W-1:0] ADR_PE_OUT  = 16'h002e;

	// ------------------------------------------------------------
	// Reset values and fills
	// ------------------------------------------------------------
	localparam logic [PD_W-1:0]   PD_DIR_RST = 8'h00;
	localparam logic [PE_W-1:0]   PE_DIR_RST = 4'h0;
	localparam logic [PE_W-1:0]   PE_OUT_RST = 4'h0;
	localparam logic [DATA_W-1:0] RD_ZERO    = 8'h00;

	// Register selected by an access
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_PD_PIN,
		SEL_PD_DIR,
		SEL_PE_PIN,
		SEL_PE_DIR,
		SEL_PE_OUT
	} pde_sel_t;

	// Virtual port target
	typedef enum logic {
		VP_PORT_D,
		VP_PORT_E
	} pde_vport_t;
endpackage : pde_pkg

// ==== verilog/pde_dir_reg.sv ====
// Direction register shared by the real and the virtual port path
`timescale 1ns/1ps
module pde_dir_reg #(
	parameter int              W   = 8,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic         clk,       // System clock
	input  wire logic         rst_n,     // Synchronous reset, low
	input  wire logic         we,        // Write strobe
	input  wire logic [W-1:0] wdata,     // Write value
	output logic      [W-1:0] q          // Current direction bits
);
	logic [W-1:0] dir_reg;
	logic [W-1:0] dir_next;

	always_comb begin
		dir_next = dir_reg;
		if (we) begin
			dir_next = wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dir_reg <= RST;
		end else begin
			dir_reg <= dir_next;
		end
	end

	assign q = dir_reg;
endmodule : pde_dir_reg

// ==== verilog/pde_out_reg.sv ====
// Output data register with per-bit toggle
`timescale 1ns/1ps
module pde_out_reg #(
	parameter int              W   = 4,
	parameter logic [W-1:0]    RST = '0
) (
	input  wire logic         clk,       // System clock
	input  wire logic         rst_n,     // Synchronous reset, low
	input  wire logic         we,        // Plain write strobe
	input  wire logic [W-1:0] wdata,     // Plain write value
	input  wire logic         tgl,       // Toggle strobe
	input  wire logic [W-1:0] tgl_mask,  // Ones invert their bit
	output logic      [W-1:0] q          // Current output data
);
	logic [W-1:0] out_reg;
	logic [W-1:0] out_next;

	always_comb begin
		out_next = out_reg;
		if (we) begin
			out_next = wdata;
		end else if (tgl) begin
			out_next = out_reg ^ tgl_mask;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_reg <= RST;
		end else begin
			out_reg <= out_next;
		end
	end

	assign q = out_reg;
endmodule : pde_out_reg

// ==== tb/pde_pins.sv ====
// Pin model for ports D and E as seen outside the register block
`timescale 1ns/1ps
module pde_pins (
	input  wire logic       clk,        // Clock
	input  wire logic       rst_n,      // Sync reset, low
	input  wire logic [7:0] pd_oe,      // Port D drive enable
	input  wire logic [7:0] pd_toggle,  // Port D toggle mask
	input  wire logic [7:0] ext_d,      // Level driven from outside, D
	input  wire logic [3:0] pe_out,     // Port E output value
	input  wire logic [3:0] pe_oe,      // Port E drive enable
	input  wire logic [3:0] ext_e,      // Level driven from outside, E
	output logic      [7:0] pd_in,      // Port D pin levels
	output logic      [3:0] pe_in       // Port E pin levels
);
	// Port D data lives out here, so the toggle lands on it
	logic [7:0] pd_dat_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) pd_dat_reg <= 8'h00;
		else pd_dat_reg <= pd_dat_reg ^ pd_toggle;
	end

	assign pd_in = (pd_oe & pd_dat_reg) | (~pd_oe & ext_d);
	assign pe_in = (pe_oe & pe_out) | (~pe_oe & ext_e);
endmodule : pde_pins

// ==== tb/pde_ports_chk.sv ====
// Port-level assertions for the port D / port E register block
`timescale 1ns/1ps
module pde_ports_chk
	import pde_pkg::*;
(
	input wire logic                       CLOCK,      // Clock
	input wire logic                       RESETN,     // Sync reset, low
	input wire logic                       IO_SEL,     // I/O-space access
	input wire logic [pde_pkg::ADDR_W-1:0] ADDR,       // Address
	input wire logic                       WR,         // Write strobe
	input wire logic                       RD,         // Read strobe
	input wire logic [pde_pkg::DATA_W-1:0] WDATA,      // Write data
	input wire logic [pde_pkg::DATA_W-1:0] RDATA,      // Read data
	input wire logic                       RVALID,     // Read valid
	input wire logic                       VP_WR,      // Virtual write
	input wire logic                       VP_RD,      // Virtual read
	input wire logic                       VP_RVALID,  // Virtual valid
	input wire logic [pde_pkg::PD_W-1:0]   PD_OE,      // D drive enable
	input wire logic [pde_pkg::PD_W-1:0]   PD_TOGGLE,  // D toggle mask
	input wire logic [pde_pkg::PE_W-1:0]   PE_OUT,     // E output value
	input wire logic [pde_pkg::PE_W-1:0]   PE_OE       // E drive enable
);
	logic [ADDR_W-1:0] da;
	logic [PE_W-1:0]   wd_lo;
	logic              hit;

	// I/O-space addresses are folded back into data space
	assign da = IO_SEL ? ({10'h000, ADDR[5:0]} + IO_OFFSET) : ADDR;
	assign wd_lo = WDATA[3:0];
	assign hit = da inside {ADR_PD_PIN, ADR_PD_DIR, ADR_PE_PIN,
		ADR_PE_DIR, ADR_PE_OUT};

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESETN);

	sequence wr_at(logic [15:0] a);
		WR && da == a;
	endsequence
	sequence rd_at(logic [15:0] a);
		RD && da == a;
	endsequence

	rd_answer_a: assert property (RD |=> RVALID)
		else $error("read not answered");
	rd_quiet_a: assert property (!RD |=> !RVALID)
		else $error("stray read valid");
	vp_answer_a: assert property (VP_RD |=> VP_RVALID)
		else $error("virtual read not answered");
	pd_dir_wr_a: assert property (
		wr_at(ADR_PD_DIR) |=> PD_OE == $past(WDATA))
		else $error("port D direction write lost");
	pe_dir_wr_a: assert property (
		wr_at(ADR_PE_DIR) |=> PE_OE == $past(wd_lo))
		else $error("port E direction write lost");
	pe_out_wr_a: assert property (
		wr_at(ADR_PE_OUT) |=> PE_OUT == $past(wd_lo))
		else $error("port E data write lost");
	pe_tgl_a: assert property (
		wr_at(ADR_PE_PIN) |=> PE_OUT == ($past(PE_OUT) ^ $past(wd_lo)))
		else $error("port E toggle wrong");
	pd_tgl_a: assert property (
		wr_at(ADR_PD_PIN) |=> PD_TOGGLE == $past(WDATA))
		else $error("port D toggle mask wrong");
	pd_tgl_idle_a: assert property (
		!(WR && da == ADR_PD_PIN) |=> PD_TOGGLE == 8'h00)
		else $error("port D toggle without write");
	pd_oe_hold_a: assert property (
		!(WR && da == ADR_PD_DIR) && !VP_WR |=> $stable(PD_OE))
		else $error("port D direction changed unasked");
	rd_pd_dir_a: assert property (
		rd_at(ADR_PD_DIR) |=> RDATA == $past(PD_OE))
		else $error("port D direction read wrong");
	rd_unmap_a: assert property (RD && !hit |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
endmodule : pde_ports_chk

bind pde_ports pde_ports_chk chk (.CLOCK(CLOCK), .RESETN(RESETN),
	.IO_SEL(IO_SEL), .ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA),
	.RDATA(RDATA), .RVALID(RVALID), .VP_WR(VP_WR), .VP_RD(VP_RD),
	.VP_RVALID(VP_RVALID), .PD_OE(PD_OE), .PD_TOGGLE(PD_TOGGLE),
	.PE_OUT(PE_OUT), .PE_OE(PE_OE));

// ==== tb/port_d_e_pin_registers_bench.sv ====
// Self-checking bench for the port D / port E register block
`timescale 1ns/1ps
module port_d_e_pin_registers_bench;
	import pde_pkg::*;
	logic        CLOCK = 0, RESETN = 0, IO_SEL = 0, WR = 0, RD = 0;
	logic        VP_WR = 0, VP_RD = 0, VP_PORT = 0, RVALID, VP_RVALID;
	logic [15:0] ADDR = 16'h0000;
	logic [7:0]  WDATA = 8'h00, VP_WDATA = 8'h00, RDATA, VP_RDATA;
	logic [7:0]  PD_IN, PD_OE, PD_TOGGLE, ext_d = 8'h3c;
	logic [3:0]  PE_IN, PE_OUT, PE_OE, ext_e = 4'h9;
	int          err_total = 0, checks_done = 0, cyc = 0;

	always #2 CLOCK = ~CLOCK;

	pde_ports dut (.CLOCK(CLOCK), .RESETN(RESETN), .IO_SEL(IO_SEL),
		.ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA), .RDATA(RDATA),
		.RVALID(RVALID), .VP_WR(VP_WR), .VP_RD(VP_RD), .VP_PORT(VP_PORT),
		.VP_WDATA(VP_WDATA), .VP_RDATA(VP_RDATA), .VP_RVALID(VP_RVALID),
		.PD_IN(PD_IN), .PD_OE(PD_OE), .PD_TOGGLE(PD_TOGGLE), .PE_IN(PE_IN),
		.PE_OUT(PE_OUT), .PE_OE(PE_OE));
	pde_pins pins (.clk(CLOCK), .rst_n(RESETN), .pd_oe(PD_OE),
		.pd_toggle(PD_TOGGLE), .ext_d(ext_d), .pe_out(PE_OUT),
		.pe_oe(PE_OE), .ext_e(ext_e), .pd_in(PD_IN), .pe_in(PE_IN));

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task stop_test;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// A hung handshake would otherwise run forever
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			stop_test;
		end
	end

	task wr(input logic io, input logic [15:0] a, input logic [7:0] d);
		@(posedge CLOCK);
		IO_SEL <= io; ADDR <= a; WDATA <= d; WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic io, input logic [15:0] a, input logic [7:0] e);
		@(posedge CLOCK);
		IO_SEL <= io; ADDR <= a; RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1;
		chk({7'h00, RVALID}, 8'h01);
		chk(RDATA, e);
	endtask : rd

	task vwr(input logic p, input logic [7:0] d);
		@(posedge CLOCK);
		VP_PORT <= p; VP_WDATA <= d; VP_WR <= 1'b1;
		@(posedge CLOCK);
		VP_WR <= 1'b0;
		#1;
	endtask : vwr

	task vrd(input logic p, input logic [7:0] e);
		@(posedge CLOCK);
		VP_PORT <= p; VP_RD <= 1'b1;
		@(posedge CLOCK);
		VP_RD <= 1'b0;
		#1;
		chk({7'h00, VP_RVALID}, 8'h01);
		chk(VP_RDATA, e);
	endtask : vrd

	task t_reset;
		rd(1'b0, ADR_PD_DIR, 8'h00);
		rd(1'b0, ADR_PE_DIR, 8'h00);
		rd(1'b0, ADR_PE_OUT, 8'h00);
		rd(1'b0, ADR_PE_PIN, 8'h09);
	endtask : t_reset

	task t_dir;
		wr(1'b1, 16'h000a, 8'ha5);
		chk(PD_OE, 8'ha5);
		rd(1'b0, ADR_PD_DIR, 8'ha5);
		rd(1'b1, 16'h0009, 8'h18);
		wr(1'b0, ADR_PE_DIR, 8'hff);
		rd(1'b1, 16'h000d, 8'h0f);
	endtask : t_dir

	task t_tgl;
		wr(1'b1, 16'h0009, 8'h81);
		chk(PD_TOGGLE, 8'h81);
		chk(PD_OE, 8'ha5);
		@(posedge CLOCK);
		#1;
		chk(PD_TOGGLE, 8'h00);
		rd(1'b0, ADR_PD_PIN, 8'h99);
		wr(1'b0, ADR_PE_OUT, 8'hf3);
		chk({4'h0, PE_OUT}, 8'h03);
		wr(1'b1, 16'h000c, 8'h06);
		chk({4'h0, PE_OUT}, 8'h05);
		rd(1'b0, ADR_PE_OUT, 8'h05);
		rd(1'b0, ADR_PE_PIN, 8'h05);
	endtask : t_tgl

	task t_map;
		wr(1'b0, 16'h000a, 8'h00);
		chk(PD_OE, 8'ha5);
		rd(1'b0, 16'h000a, 8'h00);
		rd(1'b1, 16'hffea, 8'h00);
	endtask : t_map

	task t_vp;
		vwr(1'b0, 8'hf0);
		chk(PD_OE, 8'hf0);
		rd(1'b0, ADR_PD_DIR, 8'hf0);
		vwr(1'b1, 8'h0a);
		chk({4'h0, PE_OE}, 8'h0a);
		vrd(1'b1, 8'h0a);
		vrd(1'b0, 8'hf0);
	endtask : t_vp

	// Reset in mid-run must clear registers that were written before
	task t_rerun;
		@(posedge CLOCK);
		RESETN <= 1'b0;
		repeat (2) @(posedge CLOCK);
		RESETN <= 1'b1;
		@(posedge CLOCK);
		#1;
		chk(PD_OE, 8'h00);
		chk({4'h0, PE_OE}, 8'h00);
		chk({4'h0, PE_OUT}, 8'h00);
		chk(PD_TOGGLE, 8'h00);
		chk(RDATA, 8'h00);
		t_reset;
	endtask : t_rerun

	initial begin
		repeat (3) @(posedge CLOCK);
		RESETN <= 1'b1;
		@(posedge CLOCK);
		t_reset;
		t_dir;
		t_tgl;
		t_map;
		t_vp;
		t_rerun;
		stop_test;
	end
endmodule : port_d_e_pin_registers_bench
